// ==== port_pin_pkg.sv ====
// Register map, field positions and reset values for the port pin block
package port_pin_pkg;
    localparam logic [11:0] OFF_PA_LATCH  = 12'h000;
    localparam logic [11:0] OFF_PA_DIR    = 12'h004;
    localparam logic [11:0] OFF_PA_PINS   = 12'h008;
    localparam logic [11:0] OFF_PB_LATCH  = 12'h00c;
    localparam logic [11:0] OFF_PB_DIR    = 12'h010;
    localparam logic [11:0] OFF_PB_PINS   = 12'h014;
    localparam logic [11:0] OFF_PD_LATCH  = 12'h018;
    localparam logic [11:0] OFF_PD_DIR    = 12'h01c;
    localparam logic [11:0] OFF_PD_PINS   = 12'h020;
    localparam logic [11:0] OFF_CTRL      = 12'h024;
    localparam logic [11:0] OFF_T0_CTRL   = 12'h028;
    localparam logic [11:0] OFF_T1_CTRL   = 12'h02c;
    localparam logic [7:0]  PA_MASK       = 8'h07;
    localparam logic [7:0]  PD_MASK       = 8'h7f;
    localparam logic [7:0]  PORT_RST      = 8'h00;
    // Control register fields
    localparam int          CTRL_PUD      = 0;
    localparam int          CTRL_SYSTEM_CLOCK_OUT_PIN    = 1;
    localparam int          CTRL_ICP_EN   = 2;
    localparam int          CTRL_EXT_IRQ_ZERO_PIN_EN  = 3;
    localparam int          CTRL_EXT_IRQ_ONE_PIN_EN  = 4;
    localparam int          CTRL_SYNC     = 5;
    localparam logic [7:0]  CTRL_MASK     = 8'h3f;
    // Timer clock select field positions
    localparam int          CS_UPPER      = 2;
    localparam int          CS_MIDDLE     = 1;
    localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;
    // Port D pin indices
    localparam int          P_RXD         = 0;
    localparam int          P_TXD         = 1;
    localparam int          P_XCK         = 2;
    localparam int          P_EXT_IRQ_ONE_PIN        = 3;
    localparam int          P_T0          = 4;
    localparam int          P_T1          = 5;
    localparam int          P_ICP         = 6;
endpackage

// ==== port_pin_regs.sv ====
// Port registers with APB access and fourth-port alternate-function overrides
`timescale 1ns/10ps
module port_pin_regs (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  port_a_pin_in,
    output logic      [7:0]  port_a_pin_out,
    output logic      [7:0]  port_a_pin_oe_n,
    output logic      [7:0]  port_a_pullup,
    input  wire logic [7:0]  port_b_pin_in,
    output logic      [7:0]  port_b_pin_out,
    output logic      [7:0]  port_b_pin_oe_n,
    output logic      [7:0]  port_b_pullup,
    input  wire logic [6:0]  port_d_pin_in,
    output logic      [6:0]  port_d_pin_out,
    output logic      [6:0]  port_d_pin_oe_n,
    output logic      [6:0]  port_d_pullup,
    output logic      [6:0]  port_d_input_en,
    input  wire logic        timer0_compare_b_out,
    input  wire logic        compare_value_override_en,
    input  wire logic        sync_clock_value_override_en,
    input  wire logic        sync_clock_value_override_val,
    input  wire logic        system_clock,
    input  wire logic        transmitter_oe,
    input  wire logic        transmitter_pin_value,
    input  wire logic        receiver_en,
    input  wire logic        receiver_pullup_oe,
    input  wire logic        sync_clock_in_en,
    output logic             capture_trigger_input,
    output logic             counter1_ext_clock_pin,
    output logic             counter0_ext_clock_pin,
    output logic             ext_irq_one_pin,
    output logic             ext_irq_zero_pin,
    output logic             serial_sync_clock_pin,
    output logic             receiver_data_in
);

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [7:0]  pa_latch;
        logic [7:0]  pa_dir;
        logic [7:0]  pb_latch;
        logic [7:0]  pb_dir;
        logic [7:0]  pd_latch;
        logic [7:0]  pd_dir;
        logic [7:0]  ctrl;
        logic [7:0]  t0_ctrl;
        logic [7:0]  t1_ctrl;
        logic [7:0]  pa_out;
        logic [7:0]  pa_oe_n;
        logic [7:0]  pa_pu;
        logic [7:0]  pb_out;
        logic [7:0]  pb_oe_n;
        logic [7:0]  pb_pu;
        logic [6:0]  pd_out;
        logic [6:0]  pd_oe_n;
        logic [6:0]  pd_pu;
        logic [6:0]  pd_ie;
        logic [6:0]  fn_in;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Byte-lane write merge, limited to implemented bits
    function automatic logic [7:0] lane_write(input logic [7:0] old, input logic [7:0] wd,
                                              input logic en, input logic [7:0] mask);
        lane_write = en ? (wd & mask) : old;
    endfunction

    // Pull-up applies only to an input whose latch bit is set and pull-ups are allowed
    function automatic logic [7:0] pull_of(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic global_pullup_disable);
        pull_of = latch & ~dir & {8{~global_pullup_disable}};
    endfunction

    logic       global_pullup_disable;
    logic       t0_ext;
    logic       t1_ext;
    logic [6:0] d_pu;
    logic [6:0] d_dir;
    logic [6:0] d_val;
    logic [6:0] d_ie;
    logic [7:0] rd;
    logic       hit;
    logic       wr;

    always_comb begin
        st_nxt = st_r;
        global_pullup_disable    = st_r.ctrl[port_pin_pkg::CTRL_PUD];
        t0_ext = st_r.t0_ctrl[port_pin_pkg::CS_UPPER] & st_r.t0_ctrl[port_pin_pkg::CS_MIDDLE];
        t1_ext = st_r.t1_ctrl[port_pin_pkg::CS_UPPER] & st_r.t1_ctrl[port_pin_pkg::CS_MIDDLE];
        // Register-derived settings, then per-pin overrides
        d_pu   = 7'(pull_of(st_r.pd_latch, st_r.pd_dir, global_pullup_disable));
        d_dir  = st_r.pd_dir[6:0];
        d_val  = st_r.pd_latch[6:0];
        d_ie   = 7'h00;
        // Toggle override is absent, so latch value is never inverted by a peripheral
        if (transmitter_oe) begin
            d_pu[port_pin_pkg::P_TXD]  = 1'b0;
            d_dir[port_pin_pkg::P_TXD] = 1'b1;
            d_val[port_pin_pkg::P_TXD] = transmitter_pin_value;
        end
        if (receiver_pullup_oe) begin
            d_pu[port_pin_pkg::P_RXD] = st_r.pd_latch[port_pin_pkg::P_RXD] & global_pullup_disable;
        end
        if (receiver_en) begin
            d_dir[port_pin_pkg::P_RXD] = 1'b0;
        end
        if (sync_clock_value_override_en) begin
            d_val[port_pin_pkg::P_XCK] = sync_clock_value_override_val;
        end else if (st_r.ctrl[port_pin_pkg::CTRL_SYSTEM_CLOCK_OUT_PIN]) begin
            d_val[port_pin_pkg::P_XCK] = system_clock;
        end
        if (compare_value_override_en) begin
            // Value only; direction stays with the register so output needs the direction bit
            d_val[port_pin_pkg::P_T1] = timer0_compare_b_out;
        end
        d_ie[port_pin_pkg::P_EXT_IRQ_ONE_PIN] = st_r.ctrl[port_pin_pkg::CTRL_EXT_IRQ_ONE_PIN_EN];
        d_ie[port_pin_pkg::P_XCK]  = st_r.ctrl[port_pin_pkg::CTRL_EXT_IRQ_ZERO_PIN_EN] | sync_clock_in_en;
        d_ie[port_pin_pkg::P_ICP]  = st_r.ctrl[port_pin_pkg::CTRL_ICP_EN];
        d_ie[port_pin_pkg::P_T1]   = t1_ext;
        d_ie[port_pin_pkg::P_T0]   = t0_ext;
        st_nxt.pd_out  = d_val;
        st_nxt.pd_oe_n = ~d_dir;
        st_nxt.pd_pu   = d_pu;
        st_nxt.pd_ie   = d_ie;
        // Gated function inputs read zero while their pin's input enable is off; pin 2 has one enable for both its functions
        st_nxt.fn_in   = port_d_pin_in & d_ie;
        st_nxt.fn_in[port_pin_pkg::P_RXD] = port_d_pin_in[port_pin_pkg::P_RXD];
        st_nxt.pa_out  = st_r.pa_latch;
        st_nxt.pa_oe_n = ~st_r.pa_dir;
        st_nxt.pa_pu   = pull_of(st_r.pa_latch, st_r.pa_dir, global_pullup_disable);
        st_nxt.pb_out  = st_r.pb_latch;
        st_nxt.pb_oe_n = ~st_r.pb_dir;
        st_nxt.pb_pu   = pull_of(st_r.pb_latch, st_r.pb_dir, global_pullup_disable);

        // APB slave: one wait-free access, answer in the access cycle
        hit = 1'b1;
        rd  = 8'h00;
        case (paddr)
            port_pin_pkg::OFF_PA_LATCH: rd = st_r.pa_latch;
            port_pin_pkg::OFF_PA_DIR:   rd = st_r.pa_dir;
            port_pin_pkg::OFF_PA_PINS:  rd = port_a_pin_in & port_pin_pkg::PA_MASK;
            port_pin_pkg::OFF_PB_LATCH: rd = st_r.pb_latch;
            port_pin_pkg::OFF_PB_DIR:   rd = st_r.pb_dir;
            port_pin_pkg::OFF_PB_PINS:  rd = port_b_pin_in;
            port_pin_pkg::OFF_PD_LATCH: rd = st_r.pd_latch;
            port_pin_pkg::OFF_PD_DIR:   rd = st_r.pd_dir;
            port_pin_pkg::OFF_PD_PINS:  rd = {1'b0, port_d_pin_in};
            port_pin_pkg::OFF_CTRL:     rd = st_r.ctrl;
            port_pin_pkg::OFF_T0_CTRL:  rd = st_r.t0_ctrl;
            port_pin_pkg::OFF_T1_CTRL:  rd = st_r.t1_ctrl;
            default:                    hit = 1'b0;
        endcase
        wr = psel & ~penable & pwrite & pstrb[0] & hit;
        st_nxt.pready  = psel & ~penable;
        st_nxt.pslverr = psel & ~penable & ~hit;
        st_nxt.prdata  = (psel & ~penable & ~pwrite) ? {24'h000000, rd} : port_pin_pkg::DATA_ZERO;
        st_nxt.pa_latch = lane_write(st_r.pa_latch, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_PA_LATCH,
                                     port_pin_pkg::PA_MASK);
        st_nxt.pa_dir   = lane_write(st_r.pa_dir, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_PA_DIR,
                                     port_pin_pkg::PA_MASK);
        st_nxt.pb_latch = lane_write(st_r.pb_latch, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_PB_LATCH,
                                     8'hff);
        st_nxt.pb_dir   = lane_write(st_r.pb_dir, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_PB_DIR,
                                     8'hff);
        st_nxt.pd_latch = lane_write(st_r.pd_latch, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_PD_LATCH,
                                     port_pin_pkg::PD_MASK);
        st_nxt.pd_dir   = lane_write(st_r.pd_dir, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_PD_DIR,
                                     port_pin_pkg::PD_MASK);
        st_nxt.ctrl     = lane_write(st_r.ctrl, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_CTRL,
                                     port_pin_pkg::CTRL_MASK);
        st_nxt.t0_ctrl  = lane_write(st_r.t0_ctrl, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_T0_CTRL, 8'hff);
        st_nxt.t1_ctrl  = lane_write(st_r.t1_ctrl, pwdata[7:0], wr && paddr == port_pin_pkg::OFF_T1_CTRL, 8'hff);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.pa_oe_n  <= 8'hff;
            st_r.pb_oe_n  <= 8'hff;
            st_r.pd_oe_n  <= 7'h7f;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata                 = st_r.prdata;
    assign pready                 = st_r.pready;
    assign pslverr                = st_r.pslverr;
    assign port_a_pin_out         = st_r.pa_out;
    assign port_a_pin_oe_n        = st_r.pa_oe_n;
    assign port_a_pullup          = st_r.pa_pu;
    assign port_b_pin_out         = st_r.pb_out;
    assign port_b_pin_oe_n        = st_r.pb_oe_n;
    assign port_b_pullup          = st_r.pb_pu;
    assign port_d_pin_out         = st_r.pd_out;
    assign port_d_pin_oe_n        = st_r.pd_oe_n;
    assign port_d_pullup          = st_r.pd_pu;
    assign port_d_input_en        = st_r.pd_ie;
    assign capture_trigger_input  = st_r.fn_in[port_pin_pkg::P_ICP];
    assign counter1_ext_clock_pin = st_r.fn_in[port_pin_pkg::P_T1];
    assign counter0_ext_clock_pin = st_r.fn_in[port_pin_pkg::P_T0];
    assign ext_irq_one_pin        = st_r.fn_in[port_pin_pkg::P_EXT_IRQ_ONE_PIN];
    assign ext_irq_zero_pin       = st_r.fn_in[port_pin_pkg::P_XCK];
    assign serial_sync_clock_pin  = st_r.fn_in[port_pin_pkg::P_XCK];
    assign receiver_data_in       = st_r.fn_in[port_pin_pkg::P_RXD];

endmodule

// ==== port_pin_regs_monitor.sv ====
// Concurrent checks on the ports of the port pin block
`timescale 1ns/10ps
module port_pin_regs_monitor (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [6:0]  port_d_pin_in,
    input wire logic [6:0]  port_d_pin_out,
    input wire logic [6:0]  port_d_pin_oe_n,
    input wire logic [6:0]  port_d_pullup,
    input wire logic [6:0]  port_d_input_en,
    input wire logic        capture_trigger_input,
    input wire logic        timer0_compare_b_out,
    input wire logic        compare_value_override_en,
    input wire logic        sync_clock_value_override_en,
    input wire logic        sync_clock_value_override_val,
    input wire logic        transmitter_oe,
    input wire logic        transmitter_pin_value,
    input wire logic        receiver_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero");
    a_tx_pin_forced: assert property (transmitter_oe |=> !port_d_pin_oe_n[1] && !port_d_pullup[1]
        && port_d_pin_out[1] == $past(transmitter_pin_value)) else $error("pin 1 not forced by transmitter");
    a_rx_pin_input: assert property (receiver_en |=> port_d_pin_oe_n[0]) else $error("pin 0 not input");
    a_cmp_value_pass: assert property (compare_value_override_en |=>
        port_d_pin_out[5] == $past(timer0_compare_b_out)) else $error("pin 5 value not from compare");
    a_sync_value_pass: assert property (sync_clock_value_override_en |=>
        port_d_pin_out[2] == $past(sync_clock_value_override_val)) else $error("pin 2 value not from sync clock");
    a_capture_follows: assert property (port_d_input_en[6] && $past(port_d_input_en[6]) |->
        capture_trigger_input == $past(port_d_pin_in[6])) else $error("capture input not following pin 6");
    cover property (transmitter_oe);
    cover property (pslverr);
    cover property (compare_value_override_en && timer0_compare_b_out);
endmodule
bind port_pin_regs port_pin_regs_monitor port_pin_regs_monitor_inst (.*);

// ==== board_pins.sv ====
// Board-side model of the signals on one port's package pins
`timescale 1ns/10ps
module board_pins #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe_n,
    input  wire logic [W-1:0] pull_en,
    input  wire logic [W-1:0] ext_level,
    input  wire logic [W-1:0] ext_float,
    output logic      [W-1:0] pin_level
);
    // A released pin with nothing attached reads its pull-up enable, low when the pull-up is off
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin_level[i] = !pin_oe_n[i] ? pin_out[i] : (ext_float[i] ? pull_en[i] : ext_level[i]);
        end
    end
endmodule

// ==== test_port_pin_regs.sv ====
// Self-checking bench for the port pin block
`timescale 1ns/10ps
module test_port_pin_regs;
    logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready, pslverr, serr;
    logic [7:0]  port_a_pin_in, port_a_pin_out, port_a_pin_oe_n, port_a_pullup;
    logic [7:0]  port_b_pin_in, port_b_pin_out, port_b_pin_oe_n, port_b_pullup;
    logic [6:0]  port_d_pin_in, port_d_pin_out, port_d_pin_oe_n, port_d_pullup, port_d_input_en;
    logic        timer0_compare_b_out = 1'b0, compare_value_override_en = 1'b0, system_clock = 1'b0;
    logic        sync_clock_value_override_en = 1'b0, sync_clock_value_override_val = 1'b0;
    logic        transmitter_oe = 1'b0, transmitter_pin_value = 1'b0, receiver_en = 1'b0;
    logic        receiver_pullup_oe = 1'b0, sync_clock_in_en = 1'b0;
    logic        capture_trigger_input, counter1_ext_clock_pin, counter0_ext_clock_pin;
    logic        ext_irq_one_pin, ext_irq_zero_pin, serial_sync_clock_pin, receiver_data_in;
    // Board levels live in variables so a scenario can move them
    logic [7:0]  ext_a_level = 8'hf0, ext_a_float = 8'h00, ext_b_level = 8'h3c, ext_b_float = 8'h80;
    logic [6:0]  ext_d_level = 7'h7c, ext_d_float = 7'h00;
    int          err_count = 0;
    int          n_checks = 0;
    port_pin_regs port_pin_regs_inst (.*);
    board_pins #(.W(8)) board_a_inst (.pin_out(port_a_pin_out), .pin_oe_n(port_a_pin_oe_n), .pull_en(port_a_pullup),
        .ext_level(ext_a_level), .ext_float(ext_a_float), .pin_level(port_a_pin_in));
    board_pins #(.W(8)) board_b_inst (.pin_out(port_b_pin_out), .pin_oe_n(port_b_pin_oe_n), .pull_en(port_b_pullup),
        .ext_level(ext_b_level), .ext_float(ext_b_float), .pin_level(port_b_pin_in));
    board_pins #(.W(7)) board_d_inst (.pin_out(port_d_pin_out), .pin_oe_n(port_d_pin_oe_n), .pull_en(port_d_pullup),
        .ext_level(ext_d_level), .ext_float(ext_d_float), .pin_level(port_d_pin_in));
    always #12.5 core_clk = ~core_clk;
    task automatic summarize();
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] v);
        int t;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge core_clk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        if (pready !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t no pready on bus transfer", $time);
            summarize();
        end
        v = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] v;
        apb(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        apb(1'b0, a, 8'h00, v);
        check(v, exp);
    endtask
    // One register stage sits between a stimulus change and the pin outputs, two before the function inputs
    task automatic settle();
        repeat (3) @(posedge core_clk);
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(port_pin_pkg::OFF_PA_LATCH, 32'h0);
        rd(port_pin_pkg::OFF_PA_DIR, 32'h0);
        rd(port_pin_pkg::OFF_PB_DIR, 32'h0);
        wr(port_pin_pkg::OFF_PA_LATCH, 8'hff);
        rd(port_pin_pkg::OFF_PA_LATCH, 32'h7);
        wr(port_pin_pkg::OFF_PA_DIR, 8'hfd);
        rd(port_pin_pkg::OFF_PA_DIR, 32'h5);
        rd(port_pin_pkg::OFF_PA_PINS, 32'h5);
        wr(port_pin_pkg::OFF_PB_LATCH, 8'ha5);
        wr(port_pin_pkg::OFF_PB_DIR, 8'h0f);
        pstrb <= 4'he;
        wr(port_pin_pkg::OFF_PB_LATCH, 8'h00);
        pstrb <= 4'hf;
        rd(port_pin_pkg::OFF_PB_LATCH, 32'ha5);
        rd(port_pin_pkg::OFF_PB_DIR, 32'h0f);
        rd(port_pin_pkg::OFF_PB_PINS, 32'hb5);
        wr(12'hffc, 8'h55);
        check(serr, 1'b1);
        rd(12'hffc, 32'h0);
        wr(port_pin_pkg::OFF_PD_LATCH, 8'h03);
        wr(port_pin_pkg::OFF_PD_DIR, 8'h20);
        compare_value_override_en <= 1'b1;
        timer0_compare_b_out <= 1'b1;
        settle();
        check({port_d_pin_oe_n[5], port_d_pin_out[5]}, 2'b01);
        timer0_compare_b_out <= 1'b0;
        settle();
        check(port_d_pin_out[5], 1'b0);
        wr(port_pin_pkg::OFF_PD_DIR, 8'h01);
        receiver_en <= 1'b1;
        transmitter_oe <= 1'b1;
        transmitter_pin_value <= 1'b1;
        receiver_pullup_oe <= 1'b1;
        settle();
        check({port_d_pin_oe_n[5], port_d_pin_oe_n[0]}, 2'b11);
        check({port_d_pin_oe_n[1], port_d_pin_out[1], port_d_pullup[1]}, 3'b010);
        check(port_d_pullup[0], 1'b0);
        wr(port_pin_pkg::OFF_CTRL, 8'h01);
        wr(port_pin_pkg::OFF_T1_CTRL, 8'h04);
        wr(port_pin_pkg::OFF_T0_CTRL, 8'h02);
        settle();
        check(port_d_pullup[0], 1'b1);
        check(port_d_input_en, 7'h00);
        check({capture_trigger_input, counter1_ext_clock_pin, counter0_ext_clock_pin}, 3'b000);
        sync_clock_in_en <= 1'b1;
        settle();
        check({port_d_input_en, serial_sync_clock_pin}, 8'h09);
        sync_clock_in_en <= 1'b0;
        wr(port_pin_pkg::OFF_T1_CTRL, 8'h06);
        wr(port_pin_pkg::OFF_T0_CTRL, 8'h06);
        wr(port_pin_pkg::OFF_CTRL, 8'h1d);
        settle();
        check(port_d_input_en, 7'h7c);
        check({capture_trigger_input, counter1_ext_clock_pin, counter0_ext_clock_pin}, 3'b111);
        check({ext_irq_one_pin, ext_irq_zero_pin}, 2'b11);
        wr(port_pin_pkg::OFF_CTRL, 8'h02);
        system_clock <= 1'b1;
        settle();
        check(port_d_pin_out[2], 1'b1);
        system_clock <= 1'b0;
        settle();
        check(port_d_pin_out[2], 1'b0);
        sync_clock_value_override_en <= 1'b1;
        sync_clock_value_override_val <= 1'b1;
        settle();
        check(port_d_pin_out[2], 1'b1);
        summarize();
    end
    // The sequence needs well under a thousand cycles
    initial begin
        #100000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
endmodule
